// ===== shared/scsm_defines.vh
// Register offsets, field positions, reset values and timing counts
`ifndef SCSM_DEFINES_VH
`define SCSM_DEFINES_VH

`define SCSM_OFS_CTRL        8'h00
`define SCSM_OFS_CFG         8'h04
`define SCSM_OFS_CLKINT      8'h08
`define SCSM_OFS_FAST_RST    8'h0C
`define SCSM_OFS_SLOW_RST    8'h10
`define SCSM_OFS_BDCTRL      8'h20
`define SCSM_OFS_CTRLSTS     8'h24

// clock_control fields
`define SCSM_CTRL_IFO_EN     0
`define SCSM_CTRL_IFO_RDY    1
`define SCSM_CTRL_TRIM_LO    3
`define SCSM_CTRL_CAL_LO     8
`define SCSM_CTRL_EFO_EN     16
`define SCSM_CTRL_EFO_RDY    17
`define SCSM_CTRL_EFO_BYP    18
`define SCSM_CTRL_MON_EN     19
`define SCSM_CTRL_PLL_EN     24
`define SCSM_CTRL_PLL_RDY    25
`define SCSM_TRIM_RST        5'h10

// clock_configuration fields
`define SCSM_CFG_SEL_LO      0
`define SCSM_CFG_STS_LO      2
`define SCSM_CFG_AHB_LO      4
`define SCSM_CFG_APB1_LO     8
`define SCSM_CFG_APB2_LO     11
`define SCSM_CFG_PLL_SRC     16
`define SCSM_CFG_PLL_HALF    17
`define SCSM_CFG_MUL_LO      18
`define SCSM_CFG_USB_LO      22
`define SCSM_CFG_MCO_LO      24
`define SCSM_CFG_MUL_HI      27
`define SCSM_CFG_MCOPRE_LO   28
`define SCSM_MCOPRE_RST      4'h2

// clock_interrupt fields
`define SCSM_INT_FAIL_FLAG   7
`define SCSM_INT_FAIL_CLR    23

// backup control and control/status fields
`define SCSM_BD_LSE_EN       0
`define SCSM_BD_LSE_RDY      1
`define SCSM_BD_RTC_LO       8
`define SCSM_BD_RTC_EN       15
`define SCSM_BD_SOFT_RST     16
`define SCSM_CS_LSI_EN       0
`define SCSM_CS_LSI_RDY      1

// System clock source codes
`define SCSM_SRC_IFO         2'b00
`define SCSM_SRC_EFO         2'b01
`define SCSM_SRC_PLL         2'b10

// Timing
`define SCSM_CLK_MHZ         200
`define SCSM_EFO_STARTUP_US  10
`define SCSM_EFO_STARTUP_CYC (`SCSM_EFO_STARTUP_US * `SCSM_CLK_MHZ)
`define SCSM_SWITCH_GAP_CYC  3

`endif

// ===== core/scsm_delay.v
// Start-up delay counter: done after CYCLES cycles of a steady start level
`timescale 1ns/1ps
`default_nettype none
module scsm_delay #(
   parameter CYCLES = 2000,
   parameter WIDTH  = 12
) (
   input  wire clk_sys,
   input  wire rst_n,
   input  wire start,
   output reg  done_q
);
   reg [WIDTH-1:0] cnt_q;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q  <= {WIDTH{1'b0}};
         done_q <= 1'b0;
      end else if (!start) begin
         cnt_q  <= {WIDTH{1'b0}};
         done_q <= 1'b0;
      end else if (cnt_q == CYCLES[WIDTH-1:0] - 1'b1) begin
         done_q <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + 1'b1;
      end
   end
endmodule
`default_nettype wire

// ===== core/scsm_clk_switch.v
// Break-before-make system clock source switch
`timescale 1ns/1ps
`include "scsm_defines.vh"
`default_nettype none
module scsm_clk_switch #(
   parameter GAP = `SCSM_SWITCH_GAP_CYC
) (
   input  wire       clk_sys,
   input  wire       rst_n,
   input  wire [1:0] req_sel,
   input  wire [2:0] src_ready,
   output reg  [1:0] cur_sel_q,
   output reg  [2:0] gate_q
);
   localparam RUN = 1'b0;
   localparam GAPW = 1'b1;

   reg       state_q;
   reg [1:0] pend_q;
   reg [3:0] cnt_q;

   function [2:0] onehot;
      input [1:0] s;
      begin
         case (s)
            2'd0:    onehot = 3'b001;
            2'd1:    onehot = 3'b010;
            2'd2:    onehot = 3'b100;
            default: onehot = 3'b000;
         endcase
      end
   endfunction

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q   <= RUN;
         cur_sel_q <= `SCSM_SRC_IFO; // RULE1
         gate_q    <= 3'b001; // RULE1
         pend_q    <= 2'd0;
         cnt_q     <= 4'h0;
      end else begin
         case (state_q)
            RUN: begin
               // Old source keeps running until the target is ready
               if (req_sel != cur_sel_q && req_sel != 2'd3 &&
                   src_ready[req_sel]) begin // RULE3
                  gate_q  <= 3'b000; // RULE23
                  pend_q  <= req_sel;
                  cnt_q   <= 4'h0;
                  state_q <= GAPW;
               end
            end
            GAPW: begin
               // All gates low for GAP cycles so no runt pulse escapes
               if (cnt_q == GAP[3:0] - 1'b1) begin // RULE23
                  cur_sel_q <= pend_q;
                  gate_q    <= onehot(pend_q);
                  state_q   <= RUN;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            default: state_q <= RUN;
         endcase
      end
   end
endmodule
`default_nettype wire

// ===== core/scsm_top.v
// Clock select, clock monitor and clock control registers on AHB
`timescale 1ns/1ps
`include "scsm_defines.vh"
`default_nettype none
// Behaviour
// RULE1: System clock runs from internal fast oscillator after every reset.
// RULE2: Internal fast oscillator cannot be stopped while feeding system clock.
// RULE3: Source change waits for target ready; old source runs meanwhile.
// RULE4: Ready bits and current system clock source are readable.
// RULE5: Monitor arms after external oscillator startup delay, off with it.
// RULE6: Detected external clock failure switches external oscillator off.
// RULE7: Failure pulses break inputs of both advanced timers.
// RULE8: Failure sets fail flag, which drives the non-maskable request.
// RULE9: Non-maskable request stays high until the fail flag is cleared.
// RULE10: Software writes one to fail clear bit in its handler.
// RULE11: Failure with external source feeding system clock reverts to internal.
// RULE12: Failure with external source feeding the PLL turns PLL off.
// RULE13: Two-bit field picks external/128, external slow or internal slow.
// RULE14: Realtime clock source locks after writing until backup reset.
// RULE15: Backup writes need the backup write unlock set first.
// RULE16: Started watchdog forces internal slow oscillator on.
// RULE17: Watchdog gets internal slow clock only once it is stable.
// RULE18: Three-bit field routes one of four clocks to output pin.
// RULE19: Software sets up port alternate function for clock output.
// RULE20: All registers are reachable over AHB.
// RULE21: Each oscillator output is withheld until its ready flag is set.
// RULE22: PLL input, divider and multiplier locked while PLL enabled.
// RULE23: System clock switching is glitch free.
// RULE24: Output codes 0..3 give system, internal, external, PLL/2; else none.
module scsm_top #(
   parameter STARTUP_CYCLES = `SCSM_EFO_STARTUP_CYC
) (
   input  wire        clk_sys,
   input  wire        rst_n,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire        ifo_ready,
   input  wire        efo_ready,
   input  wire        pll_ready,
   input  wire        lse_ready,
   input  wire        lsi_ready,
   input  wire [7:0]  ifo_factory_cal,
   input  wire        efo_clk_missing,
   input  wire        wdg_started,
   input  wire        backup_domain_reset,
   input  wire        backup_write_unlock,
   output reg         ifo_enable,
   output reg         efo_enable,
   output reg         efo_bypass,
   output reg         pll_enable,
   output reg         lse_enable,
   output reg         lsi_enable,
   output reg  [4:0]  osc_release,
   output wire [2:0]  sys_gate,
   output reg  [3:0]  mco_gate,
   output reg  [1:0]  rtc_source,
   output reg         rtc_enable,
   output reg         wdg_clk_enable,
   output reg         timer_one_break,
   output reg         timer_two_break,
   output reg         nmi_request,
   output reg         pll_source,
   output reg         pll_efo_half,
   output reg  [4:0]  pll_mult,
   output reg  [4:0]  ifo_trim,
   output reg  [31:0] fast_periph_reset,
   output reg  [31:0] slow_periph_reset
);
   // Address phase capture
   reg         wr_q;
   reg  [7:0]  addr_q;
   // Stored fields
   reg         mon_en_q;
   reg  [1:0]  sel_req_q;
   reg  [3:0]  ahb_pre_q;
   reg  [2:0]  apb1_pre_q;
   reg  [2:0]  apb2_pre_q;
   reg  [1:0]  usb_pre_q;
   reg  [2:0]  mco_sel_q;
   reg  [3:0]  mco_pre_q;
   reg         fail_flag_q;
   reg         rtc_lock_q;
   reg         wdg_lock_q;
   wire [1:0]  cur_sel;
   wire        mon_armed;
   wire        bus_take;
   wire        wr_en;
   wire        fail_evt;
   wire        ifo_in_use;
   wire        efo_in_use;
   wire        bk_reset;
   reg  [31:0] rd_mux;
   function [3:0] mco_decode;
      input [2:0] code;
      begin
         case (code)
            3'd0:    mco_decode = 4'b0001;
            3'd1:    mco_decode = 4'b0010;
            3'd2:    mco_decode = 4'b0100;
            3'd3:    mco_decode = 4'b1000;
            default: mco_decode = 4'b0000;
         endcase
      end
   endfunction
   function sel_hit;
      input [7:0] a;
      input [7:0] ofs;
      begin
         sel_hit = (a[7:2] == ofs[7:2]);
      end
   endfunction
   assign bus_take = hsel & hready & htrans[1]; // RULE20
   assign wr_en    = wr_q;
   // Internal fast oscillator in use directly or as PLL input
   assign ifo_in_use = (cur_sel == `SCSM_SRC_IFO) ||
                       (cur_sel == `SCSM_SRC_PLL && !pll_source);
   assign efo_in_use = (cur_sel == `SCSM_SRC_EFO) ||
                       (cur_sel == `SCSM_SRC_PLL && pll_source);
   scsm_delay #(
      .CYCLES (STARTUP_CYCLES),
      .WIDTH  (24)
   ) u_efo_delay (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .start   (efo_enable & mon_en_q),
      .done_q  (mon_armed)
   ); // RULE5
   // Monitor drops when the oscillator is switched off
   assign fail_evt = mon_armed & efo_enable & efo_clk_missing; // RULE5
   scsm_clk_switch u_switch (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .req_sel   (sel_req_q),
      .src_ready ({osc_release[2], osc_release[1], osc_release[0]}),
      .cur_sel_q (cur_sel),
      .gate_q    (sys_gate)
   ); // RULE23
   assign bk_reset = backup_domain_reset |
      (wr_en && sel_hit(addr_q, `SCSM_OFS_BDCTRL) &&
       backup_write_unlock && hwdata[`SCSM_BD_SOFT_RST]);
   // Bus phase and answer; zero wait states, unmapped reads return zero
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_q      <= 1'b0;
         addr_q    <= 8'h00;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wr_q <= bus_take & hwrite;
         if (bus_take) begin
            addr_q <= haddr[7:0];
         end
         if (bus_take && !hwrite) begin
            hrdata <= rd_mux;
         end
      end
   end
   // Read mux
   always @* begin
      rd_mux = 32'h0000_0000;
      case (haddr[7:2])
         `SCSM_OFS_CTRL >> 2: begin
            rd_mux[`SCSM_CTRL_IFO_EN]  = ifo_enable;
            rd_mux[`SCSM_CTRL_IFO_RDY] = ifo_ready; // RULE4
            rd_mux[`SCSM_CTRL_TRIM_LO +: 5] = ifo_trim;
            rd_mux[`SCSM_CTRL_CAL_LO +: 8]  = ifo_factory_cal;
            rd_mux[`SCSM_CTRL_EFO_EN]  = efo_enable;
            rd_mux[`SCSM_CTRL_EFO_RDY] = efo_ready; // RULE4
            rd_mux[`SCSM_CTRL_EFO_BYP] = efo_bypass;
            rd_mux[`SCSM_CTRL_MON_EN]  = mon_en_q;
            rd_mux[`SCSM_CTRL_PLL_EN]  = pll_enable;
            rd_mux[`SCSM_CTRL_PLL_RDY] = pll_ready; // RULE4
         end
         `SCSM_OFS_CFG >> 2: begin
            rd_mux[`SCSM_CFG_SEL_LO +: 2]   = sel_req_q;
            rd_mux[`SCSM_CFG_STS_LO +: 2]   = cur_sel; // RULE4
            rd_mux[`SCSM_CFG_AHB_LO +: 4]   = ahb_pre_q;
            rd_mux[`SCSM_CFG_APB1_LO +: 3]  = apb1_pre_q;
            rd_mux[`SCSM_CFG_APB2_LO +: 3]  = apb2_pre_q;
            rd_mux[`SCSM_CFG_PLL_SRC]       = pll_source;
            rd_mux[`SCSM_CFG_PLL_HALF]      = pll_efo_half;
            rd_mux[`SCSM_CFG_MUL_LO +: 4]   = pll_mult[3:0];
            rd_mux[`SCSM_CFG_USB_LO +: 2]   = usb_pre_q;
            rd_mux[`SCSM_CFG_MCO_LO +: 3]   = mco_sel_q;
            rd_mux[`SCSM_CFG_MUL_HI]        = pll_mult[4];
            rd_mux[`SCSM_CFG_MCOPRE_LO +: 4] = mco_pre_q;
         end
         `SCSM_OFS_CLKINT >> 2:
            rd_mux[`SCSM_INT_FAIL_FLAG] = fail_flag_q;
         `SCSM_OFS_FAST_RST >> 2: rd_mux = fast_periph_reset;
         `SCSM_OFS_SLOW_RST >> 2: rd_mux = slow_periph_reset;
         `SCSM_OFS_BDCTRL >> 2: begin
            rd_mux[`SCSM_BD_LSE_EN]     = lse_enable;
            rd_mux[`SCSM_BD_LSE_RDY]    = lse_ready;
            rd_mux[`SCSM_BD_RTC_LO +: 2] = rtc_source;
            rd_mux[`SCSM_BD_RTC_EN]     = rtc_enable;
         end
         `SCSM_OFS_CTRLSTS >> 2: begin
            rd_mux[`SCSM_CS_LSI_EN]  = lsi_enable;
            rd_mux[`SCSM_CS_LSI_RDY] = lsi_ready;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end
   // Oscillator, PLL and system clock control
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ifo_enable   <= 1'b1; // RULE1
         efo_enable   <= 1'b0;
         efo_bypass   <= 1'b0;
         mon_en_q     <= 1'b0;
         pll_enable   <= 1'b0;
         ifo_trim     <= `SCSM_TRIM_RST;
         sel_req_q    <= `SCSM_SRC_IFO; // RULE1
         ahb_pre_q    <= 4'h0;
         apb1_pre_q   <= 3'h0;
         apb2_pre_q   <= 3'h0;
         usb_pre_q    <= 2'h0;
         mco_sel_q    <= 3'h0;
         mco_pre_q    <= `SCSM_MCOPRE_RST;
         pll_source   <= 1'b0;
         pll_efo_half <= 1'b0;
         pll_mult     <= 5'h00;
      end else begin
         if (wr_en && sel_hit(addr_q, `SCSM_OFS_CTRL)) begin
            // Stop request ignored while feeding the system clock
            ifo_enable <= hwdata[`SCSM_CTRL_IFO_EN] | ifo_in_use; // RULE2
            ifo_trim   <= hwdata[`SCSM_CTRL_TRIM_LO +: 5];
            efo_enable <= hwdata[`SCSM_CTRL_EFO_EN];
            efo_bypass <= hwdata[`SCSM_CTRL_EFO_BYP];
            mon_en_q   <= hwdata[`SCSM_CTRL_MON_EN];
            pll_enable <= hwdata[`SCSM_CTRL_PLL_EN];
         end
         if (wr_en && sel_hit(addr_q, `SCSM_OFS_CFG)) begin
            sel_req_q  <= hwdata[`SCSM_CFG_SEL_LO +: 2]; // RULE3
            ahb_pre_q  <= hwdata[`SCSM_CFG_AHB_LO +: 4];
            apb1_pre_q <= hwdata[`SCSM_CFG_APB1_LO +: 3];
            apb2_pre_q <= hwdata[`SCSM_CFG_APB2_LO +: 3];
            usb_pre_q  <= hwdata[`SCSM_CFG_USB_LO +: 2];
            mco_sel_q  <= hwdata[`SCSM_CFG_MCO_LO +: 3];
            mco_pre_q  <= hwdata[`SCSM_CFG_MCOPRE_LO +: 4];
            if (!pll_enable) begin // RULE22
               pll_source   <= hwdata[`SCSM_CFG_PLL_SRC];
               pll_efo_half <= hwdata[`SCSM_CFG_PLL_HALF];
               pll_mult     <= {hwdata[`SCSM_CFG_MUL_HI],
                                hwdata[`SCSM_CFG_MUL_LO +: 4]};
            end
         end
         // Failure overrides any write in the same cycle
         if (fail_evt) begin
            efo_enable <= 1'b0; // RULE6
            if (pll_source) begin
               pll_enable <= 1'b0; // RULE12
            end
            if (efo_in_use) begin
               ifo_enable <= 1'b1; // RULE11
               sel_req_q  <= `SCSM_SRC_IFO; // RULE11
            end
         end
      end
   end
   // Failure flag, interrupt and timer breaks
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fail_flag_q     <= 1'b0;
         nmi_request     <= 1'b0;
         timer_one_break <= 1'b0;
         timer_two_break <= 1'b0;
      end else begin
         // Set wins over a clear in the same cycle
         fail_flag_q <= fail_evt | (fail_flag_q &
            ~(wr_en && sel_hit(addr_q, `SCSM_OFS_CLKINT) &&
              hwdata[`SCSM_INT_FAIL_CLR])); // RULE8 RULE10
         nmi_request     <= fail_evt | fail_flag_q; // RULE8 RULE9
         timer_one_break <= fail_evt; // RULE7
         timer_two_break <= fail_evt; // RULE7
      end
   end
   // Backup domain: slow oscillator, realtime clock source
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lse_enable <= 1'b0;
         rtc_source <= 2'b00;
         rtc_enable <= 1'b0;
         rtc_lock_q <= 1'b0;
      end else if (bk_reset) begin
         lse_enable <= 1'b0;
         rtc_source <= 2'b00;
         rtc_enable <= 1'b0;
         rtc_lock_q <= 1'b0; // RULE14
      end else if (wr_en && sel_hit(addr_q, `SCSM_OFS_BDCTRL) &&
                   backup_write_unlock) begin // RULE15
         lse_enable <= hwdata[`SCSM_BD_LSE_EN];
         rtc_enable <= hwdata[`SCSM_BD_RTC_EN];
         // 01 external slow, 10 internal slow, 11 external fast / 128
         if (!rtc_lock_q &&
             hwdata[`SCSM_BD_RTC_LO +: 2] != 2'b00) begin // RULE13
            rtc_source <= hwdata[`SCSM_BD_RTC_LO +: 2];
            rtc_lock_q <= 1'b1; // RULE14
         end
      end
   end
   // Watchdog, slow internal oscillator, gating outputs
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wdg_lock_q        <= 1'b0;
         lsi_enable        <= 1'b1;
         wdg_clk_enable    <= 1'b0;
         osc_release       <= 5'h00;
         mco_gate          <= 4'h0;
         fast_periph_reset <= 32'h0000_0000;
         slow_periph_reset <= 32'h0000_0000;
      end else begin
         // Watchdog cannot be stopped once started, so neither can its clock
         wdg_lock_q <= wdg_lock_q | wdg_started; // RULE16
         if (wdg_started | wdg_lock_q) begin
            lsi_enable <= 1'b1; // RULE16
         end else if (wr_en && sel_hit(addr_q, `SCSM_OFS_CTRLSTS)) begin
            lsi_enable <= hwdata[`SCSM_CS_LSI_EN];
         end
         wdg_clk_enable <= (wdg_started | wdg_lock_q) &
                           lsi_enable & lsi_ready; // RULE17
         // Order: ifo, efo, pll, lse, lsi
         osc_release <= {lsi_enable & lsi_ready,
                         lse_enable & lse_ready,
                         pll_enable & pll_ready,
                         efo_enable & efo_ready,
                         ifo_enable & ifo_ready}; // RULE21
         mco_gate <= mco_decode(mco_sel_q); // RULE18 RULE24
         if (wr_en && sel_hit(addr_q, `SCSM_OFS_FAST_RST)) begin
            fast_periph_reset <= hwdata;
         end
         if (wr_en && sel_hit(addr_q, `SCSM_OFS_SLOW_RST)) begin
            slow_periph_reset <= hwdata;
         end
      end
   end
endmodule
`default_nettype wire

// ===== verif/scsm_properties.sv
// Port assertions for the clock select and monitor block
`timescale 1ns/1ps
`default_nettype none
module scsm_properties #(
   parameter STARTUP_CYCLES = 2000
) (
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        lsi_ready,
   input wire logic        wdg_started,
   input wire logic        backup_domain_reset,
   input wire logic        ifo_enable,
   input wire logic        efo_enable,
   input wire logic        pll_enable,
   input wire logic        lsi_enable,
   input wire logic [4:0]  osc_release,
   input wire logic [2:0]  sys_gate,
   input wire logic [3:0]  mco_gate,
   input wire logic [1:0]  rtc_source,
   input wire logic        wdg_clk_enable,
   input wire logic        timer_one_break,
   input wire logic        timer_two_break,
   input wire logic        nmi_request,
   input wire logic        pll_source
);
   // Any taken write, since a clear may hide in its data phase
   wire wr_take = hsel && hready && htrans[1] && hwrite;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_reset_ifo;
      $rose(rst_n) |-> sys_gate == 3'b001;
   endproperty
   a_reset_ifo: assert property (p_reset_ifo)
      else $error("system clock not internal after reset");
   property p_ifo_kept;
      (sys_gate[0] || (sys_gate[2] && !pll_source)) |-> ifo_enable;
   endproperty
   a_ifo_kept: assert property (p_ifo_kept)
      else $error("internal oscillator stopped while in use");
   property p_switch_ready;
      (sys_gate & ~$past(sys_gate) & ~$past(osc_release[2:0])) == 3'b000;
   endproperty
   a_switch_ready: assert property (p_switch_ready)
      else $error("gate opened on a source not ready");
   property p_no_glitch;
      ($past(sys_gate) != 3'b000 && sys_gate != 3'b000)
         |-> (sys_gate == $past(sys_gate) && $onehot(sys_gate));
   endproperty
   a_no_glitch: assert property (p_no_glitch)
      else $error("gate changed without a break");
   property p_switch_gap;
      $fell(|sys_gate) |=> (sys_gate == 3'b000) [*2];
   endproperty
   a_switch_gap: assert property (p_switch_gap)
      else $error("switch gap too short");
   property p_fail_response;
      $rose(timer_one_break) |-> !efo_enable && nmi_request && ifo_enable;
   endproperty
   a_fail_response: assert property (p_fail_response)
      else $error("failure response incomplete");
   property p_break_pair;
      timer_one_break |-> timer_two_break ##1 !timer_one_break;
   endproperty
   a_break_pair: assert property (p_break_pair)
      else $error("break pulses wrong");
   property p_fail_pll;
      $rose(timer_one_break) && pll_source |-> !pll_enable;
   endproperty
   a_fail_pll: assert property (p_fail_pll)
      else $error("pll left on after failure");
   property p_fail_revert;
      $rose(timer_one_break) |-> ##[0:12] sys_gate == 3'b001;
   endproperty
   a_fail_revert: assert property (p_fail_revert)
      else $error("no fallback to internal clock");
   property p_nmi_hold;
      (!wr_take) [*3] ##1 (!wr_take && nmi_request) |=> nmi_request;
   endproperty
   a_nmi_hold: assert property (p_nmi_hold)
      else $error("nmi dropped without clear");
   property p_wdg_lsi;
      wdg_started |=> lsi_enable [*8];
   endproperty
   a_wdg_lsi: assert property (p_wdg_lsi)
      else $error("slow oscillator off with watchdog");
   property p_wdg_clk;
      wdg_clk_enable |-> $past(lsi_ready) && lsi_enable;
   endproperty
   a_wdg_clk: assert property (p_wdg_clk)
      else $error("watchdog clock before stable");
   property p_rtc_lock;
      $changed(rtc_source) |-> $past(rtc_source) == 2'b00
         || $past(backup_domain_reset) || $past(hwdata[16]);
   endproperty
   a_rtc_lock: assert property (p_rtc_lock)
      else $error("rtc source changed while locked");
   property p_mco_onehot;
      $onehot0(mco_gate);
   endproperty
   a_mco_onehot: assert property (p_mco_onehot)
      else $error("clock out gates not one-hot");
   property p_bus_okay;
      hreadyout && !hresp;
   endproperty
   a_bus_okay: assert property (p_bus_okay)
      else $error("bus response not okay");
endmodule
bind scsm_top scsm_properties #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_props (.*);
`default_nettype wire

// ===== verif/tb_top.sv
// Register-level test of the clock select and monitor block
`timescale 1ns/1ps
`include "scsm_defines.vh"
`default_nettype none
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin \
   n_mismatch++; $display("unexpected %s exp %0h got %0h", nm, ex, gt); \
   end end
module tb_top;
   logic        clk_sys, rst_n, hsel, hwrite, hready, hreadyout, hresp;
   logic        ifo_ready, efo_ready, pll_ready, lse_ready, lsi_ready;
   logic        efo_clk_missing, wdg_started, backup_domain_reset;
   logic        backup_write_unlock, ifo_enable, efo_enable, efo_bypass;
   logic        pll_enable, lse_enable, lsi_enable, rtc_enable;
   logic        wdg_clk_enable, timer_one_break, timer_two_break;
   logic        nmi_request, pll_source, pll_efo_half;
   logic [1:0]  htrans, rtc_source;
   logic [2:0]  hsize, sys_gate;
   logic [3:0]  mco_gate;
   logic [4:0]  osc_release, pll_mult, ifo_trim;
   logic [7:0]  ifo_factory_cal;
   logic [31:0] haddr, hwdata, hrdata, fast_periph_reset, slow_periph_reset;
   integer      n_mismatch = 0, n_tests = 0, cyc = 0, i;
   // Short startup count keeps the monitor tests quick
   scsm_top #(.STARTUP_CYCLES(8)) dut (.*);
   initial begin
      clk_sys = 0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task end_sim;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch = n_mismatch + 1;
         end_sim;
      end
   end
   task step(input integer n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task wr(input [7:0] a, input [31:0] d);
      @(posedge clk_sys);
      hsel <= 1; htrans <= 2'h2; hwrite <= 1; haddr <= {24'h0, a};
      @(posedge clk_sys);
      hsel <= 0; htrans <= 2'h0; hwdata <= d;
      @(posedge clk_sys);
   endtask
   task rd_chk(input [7:0] a, input [31:0] m, input [31:0] e, input string nm);
      @(posedge clk_sys);
      hsel <= 1; htrans <= 2'h2; hwrite <= 0; haddr <= {24'h0, a};
      @(posedge clk_sys);
      hsel <= 0; htrans <= 2'h0;
      #1;
      `CHK(nm, e, hrdata & m)
   endtask
   initial begin
      rst_n = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2;
      hwdata = 0; hready = 1; ifo_ready = 1; efo_ready = 0; pll_ready = 0;
      lse_ready = 0; lsi_ready = 0; ifo_factory_cal = 8'h5A;
      efo_clk_missing = 0; wdg_started = 0; backup_domain_reset = 0;
      backup_write_unlock = 0;
      repeat (20) @(posedge clk_sys);
      rst_n <= 1;
      step(1);
      `CHK("sys_gate", 3'h1, sys_gate)
      rd_chk(`SCSM_OFS_CTRL, 32'hFFFFFFFF, 32'h00005A83, "ctrl");
      rd_chk(`SCSM_OFS_CFG, 32'hFFFFFFFF, 32'h20000000, "cfg");
      rd_chk(8'h14, 32'hFFFFFFFF, 32'h00000000, "unmapped");
      wr(`SCSM_OFS_CTRL, 32'h00000080);
      step(2);
      `CHK("ifo_enable", 1'b1, ifo_enable)
      // Pll fed from the external source, external selected but not ready
      wr(`SCSM_OFS_CFG, 32'h20010001);
      wr(`SCSM_OFS_CTRL, 32'h01090081);
      efo_clk_missing <= 1;
      step(3);
      `CHK("early break", 1'b0, timer_one_break)
      `CHK("efo_enable", 1'b1, efo_enable)
      `CHK("pending gate", 3'h1, sys_gate)
      efo_clk_missing <= 0;
      efo_ready <= 1;
      pll_ready <= 1;
      step(12);
      `CHK("efo release", 1'b1, osc_release[1])
      `CHK("switched gate", 3'h2, sys_gate)
      rd_chk(`SCSM_OFS_CFG, 32'hC, 32'h4, "cfg status");
      rd_chk(`SCSM_OFS_CTRL, 32'h02020000, 32'h02020000, "ready");
      wr(`SCSM_OFS_CFG, 32'h20000001);
      step(2);
      `CHK("pll_source", 1'b1, pll_source)
      efo_clk_missing <= 1;
      i = 0;
      while (timer_one_break !== 1'b1 && i < 10) begin
         @(posedge clk_sys);
         #1;
         i++;
      end
      `CHK("break one", 1'b1, timer_one_break)
      `CHK("break two", 1'b1, timer_two_break)
      `CHK("efo off", 1'b0, efo_enable)
      `CHK("pll off", 1'b0, pll_enable)
      `CHK("nmi", 1'b1, nmi_request)
      efo_clk_missing <= 0;
      efo_ready <= 0;
      step(12);
      `CHK("fallback gate", 3'h1, sys_gate)
      `CHK("nmi held", 1'b1, nmi_request)
      rd_chk(`SCSM_OFS_CLKINT, 32'h80, 32'h80, "fail flag");
      wr(`SCSM_OFS_CLKINT, 32'h00800000);
      step(3);
      `CHK("nmi cleared", 1'b0, nmi_request)
      // Backup writes are refused until unlocked
      wr(`SCSM_OFS_BDCTRL, 32'h00000100);
      step(2);
      `CHK("rtc locked out", 2'h0, rtc_source)
      backup_write_unlock <= 1;
      lse_ready <= 1;
      for (i = 1; i < 4; i++) begin
         backup_domain_reset <= 1;
         step(1);
         backup_domain_reset <= 0;
         wr(`SCSM_OFS_BDCTRL, 32'(i) << 8);
         wr(`SCSM_OFS_BDCTRL, 32'((i % 3) + 1) << 8);
         step(2);
         `CHK("rtc_source", 2'(i), rtc_source)
      end
      for (i = 0; i < 8; i++) begin
         wr(`SCSM_OFS_CFG, 32'h20000000 | (32'(i) << 24));
         step(1);
         `CHK("mco_gate", (i < 4) ? 4'(1 << i) : 4'h0, mco_gate)
      end
      wdg_started <= 1;
      step(1);
      wdg_started <= 0;
      wr(`SCSM_OFS_CTRLSTS, 32'h0);
      step(2);
      `CHK("lsi forced", 1'b1, lsi_enable)
      `CHK("wdg clk early", 1'b0, wdg_clk_enable)
      lsi_ready <= 1;
      step(3);
      `CHK("wdg clk", 1'b1, wdg_clk_enable)
      end_sim;
   end
endmodule
`default_nettype wire
